// file: hw/rsp_pkg.sv
// Constants of the radio serial host port; its transmit buffer uses none of them.
// Assumes a single 50 MHz clock domain for all logic that includes it.
package rsp_pkg;

   // ------------------------------------------------------------
   // Clock and link timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned SCLK_MAX_HZ     = 10_000_000;
   localparam int unsigned CS_SETUP_NS     = 2000;
   localparam int unsigned CS_SETUP_CYC    = (CS_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // ------------------------------------------------------------
   // Header byte layout and address map
   // ------------------------------------------------------------
   localparam int unsigned HDR_AC_BIT      = 7;
   localparam int unsigned HDR_RW_BIT      = 0;
   localparam logic [7:0]  FIFO_ADDR       = 8'hff;
   localparam logic [7:0]  IRQ_MASK_BASE   = 8'h90;
   localparam logic [7:0]  IRQ_STATUS_BASE = 8'hfa;
   localparam logic [7:0]  WIN_SPAN        = 8'h04;
   localparam logic [7:0]  ADDR_STEP       = 8'h01;
   localparam logic [2:0]  BIT_LAST        = 3'h7;
   localparam logic [2:0]  BIT_FIRST       = 3'h0;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;

   // ------------------------------------------------------------
   // Event status bits
   // ------------------------------------------------------------
   localparam int unsigned EV_TX_FIFO_ERR  = 5;
   localparam int unsigned EV_RX_FIFO_ERR  = 6;
   localparam logic [31:0] EV_IMPLEMENTED  = 32'h603f_ffff;
   localparam logic [31:0] STATUS_RST      = 32'h0000_0000;
   localparam logic [31:0] MASK_RST        = 32'h0000_0000;
   localparam logic [4:0]  GPIO_SEL_IRQ    = 5'h00;

   // ------------------------------------------------------------
   // Transfer phases
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_HEAD,
      PH_ADDR,
      PH_DATA,
      PH_IGNORE
   } rsp_phase_e;

endpackage

// file: hw/rsp_buf2.sv
// Two-entry byte buffer with valid/ready on both sides.
// Assumes both sides run on clk; drains in arrival order.
`timescale 1ns/1ps
module rsp_buf2
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [7:0] in_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic [7:0]      out_data
);

   logic [7:0] mem_r [2];
   logic [7:0] mem_nxt [2];
   logic       rd_ptr_r;
   logic       rd_ptr_nxt;
   logic       wr_ptr_r;
   logic       wr_ptr_nxt;
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   logic       push;
   logic       pop;

   assign in_ready  = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data  = mem_r[rd_ptr_r];

   always_comb
   begin
      push       = in_valid & in_ready;
      pop        = out_valid & out_ready;
      mem_nxt    = mem_r;
      rd_ptr_nxt = rd_ptr_r ^ pop;
      wr_ptr_nxt = wr_ptr_r ^ push;
      count_nxt  = count_r;
      if (push)
      begin
         mem_nxt[wr_ptr_r] = in_data;
      end
      if (push && !pop)
      begin
         count_nxt = count_r + 2'h1;
      end
      else if (pop && !push)
      begin
         count_nxt = count_r - 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_r[0] <= 8'h00;
         mem_r[1] <= 8'h00;
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end
      else
      begin
         mem_r    <= mem_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         count_r  <= count_nxt;
      end
   end

endmodule

// file: hw/rsp_port.sv
// Serial slave port of the radio with its event status and interrupt logic.
// Assumes the host drives chip select and bit clock; the register file, the
// receive FIFO and the transmit FIFO sit outside on the same clk.
`timescale 1ns/1ps

module rsp_port
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        chip_select_low,
   input  wire logic        sclk,
   input  wire logic        mosi,
   output logic             miso_o,
   output logic             miso_oe_n,
   input  wire logic [15:0] machine_status_bytes,
   output logic [7:0]       reg_addr,
   output logic             reg_wr,
   output logic [7:0]       reg_wdata,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [7:0]  rx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [7:0]       tx_data,
   input  wire logic [31:0] event_pulse,
   input  wire logic [4:0]  gpio_sel,
   output logic             gpio_out
);

   // ------------------------------------------------------------
   // Address window decode
   // ------------------------------------------------------------
   function automatic logic rsp_in_win(input logic [7:0] addr, input logic [7:0] base);
      rsp_in_win = (addr >= base) && (addr < base + rsp_pkg::WIN_SPAN);
   endfunction

   function automatic logic [1:0] rsp_win_idx(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] diff;
      diff        = addr - base;
      rsp_win_idx = diff[1:0];
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Stage 0 feeds only stage 1; edges are found between stages 1 and 2.
   logic [2:0] cs_sync_r;
   logic [2:0] cs_sync_nxt;
   logic [2:0] sck_sync_r;
   logic [2:0] sck_sync_nxt;
   logic [1:0] mosi_sync_r;
   logic [1:0] mosi_sync_nxt;

   logic cs_active;
   logic cs_fall;
   logic sck_rise;
   logic sck_fall;
   assign cs_active = ~cs_sync_r[1];
   assign cs_fall   = cs_sync_r[2] & ~cs_sync_r[1];
   assign sck_rise  = ~sck_sync_r[2] & sck_sync_r[1];
   assign sck_fall  = sck_sync_r[2] & ~sck_sync_r[1];

   // ------------------------------------------------------------
   // Transfer engine, status and mask registers
   // ------------------------------------------------------------
   rsp_pkg::rsp_phase_e phase_r;
   rsp_pkg::rsp_phase_e phase_nxt;
   logic [2:0]  bit_cnt_r;
   logic [2:0]  bit_cnt_nxt;
   logic [7:0]  in_sr_r;
   logic [7:0]  in_sr_nxt;
   logic [7:0]  out_sr_r;
   logic [7:0]  out_sr_nxt;
   logic [7:0]  nxt_byte_r;
   logic [7:0]  nxt_byte_nxt;
   logic        is_read_r;
   logic        is_read_nxt;
   logic        is_cmd_r;
   logic        is_cmd_nxt;
   logic [7:0]  addr_r;
   logic [7:0]  addr_nxt;
   logic        rd_pend_r;
   logic        rd_pend_nxt;
   logic [31:0] status_r;
   logic [31:0] status_nxt;
   logic [31:0] mask_r;
   logic [31:0] mask_nxt;
   logic        tx_hold_vld_r;
   logic        tx_hold_vld_nxt;
   logic [7:0]  tx_hold_r;
   logic [7:0]  tx_hold_nxt;
   logic        reg_wr_r;
   logic        reg_wr_nxt;
   logic [7:0]  reg_wdata_r;
   logic [7:0]  reg_wdata_nxt;
   logic        cmd_valid_r;
   logic        cmd_valid_nxt;
   logic [7:0]  cmd_code_r;
   logic [7:0]  cmd_code_nxt;
   logic        gpio_r;
   logic        gpio_nxt;
   logic        buf_in_valid;
   logic        buf_in_ready;
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic [31:0] ev_int;
   logic [31:0] clr_mask;
   logic        fetch_fifo;
   logic        fetch_stat;
   logic        fetch_mask;
   assign byte_done  = sck_rise && (bit_cnt_r == rsp_pkg::BIT_LAST);
   assign rx_byte    = {in_sr_r[6:0], mosi_sync_r[1]};
   assign fetch_fifo = rd_pend_r && (addr_r == rsp_pkg::FIFO_ADDR);
   assign fetch_stat = rd_pend_r && rsp_in_win(addr_r, rsp_pkg::IRQ_STATUS_BASE);
   assign fetch_mask = rd_pend_r && rsp_in_win(addr_r, rsp_pkg::IRQ_MASK_BASE);

   // Read handshakes toward the register file and receive FIFO are combinational
   assign reg_addr   = reg_wr_r ? addr_r - rsp_pkg::ADDR_STEP : addr_r;
   assign reg_rd     = rd_pend_r && !fetch_fifo && !fetch_stat && !fetch_mask;
   assign rx_ready   = fetch_fifo && rx_valid;
   assign reg_wr     = reg_wr_r;
   assign reg_wdata  = reg_wdata_r;
   assign cmd_valid  = cmd_valid_r;
   assign cmd_code   = cmd_code_r;
   assign miso_o     = out_sr_r[7];
   assign miso_oe_n  = cs_sync_r[1];
   assign gpio_out   = gpio_r;

   always_comb
   begin
      phase_nxt       = phase_r;
      bit_cnt_nxt     = bit_cnt_r;
      in_sr_nxt       = in_sr_r;
      out_sr_nxt      = out_sr_r;
      nxt_byte_nxt    = nxt_byte_r;
      is_read_nxt     = is_read_r;
      is_cmd_nxt      = is_cmd_r;
      addr_nxt        = addr_r;
      rd_pend_nxt     = 1'b0;
      mask_nxt        = mask_r;
      tx_hold_vld_nxt = tx_hold_vld_r;
      tx_hold_nxt     = tx_hold_r;
      reg_wr_nxt      = 1'b0;
      reg_wdata_nxt   = reg_wdata_r;
      cmd_valid_nxt   = 1'b0;
      cmd_code_nxt    = cmd_code_r;
      buf_in_valid    = 1'b0;
      ev_int          = 32'h0000_0000;
      clr_mask        = 32'h0000_0000;
      cs_sync_nxt     = {cs_sync_r[1:0], chip_select_low};
      sck_sync_nxt    = {sck_sync_r[1:0], sclk};
      mosi_sync_nxt   = {mosi_sync_r[0], mosi};
      // Port runs from clk alone, so every power state keeps it alive
      if (!cs_active)
         phase_nxt = rsp_pkg::PH_IDLE;
      else if (cs_fall)
      begin
         phase_nxt    = rsp_pkg::PH_HEAD;
         bit_cnt_nxt  = rsp_pkg::BIT_FIRST;
         out_sr_nxt   = machine_status_bytes[15:8];
         nxt_byte_nxt = machine_status_bytes[7:0];
         // A byte written last transaction is only committed now
         if (tx_hold_vld_r)
         begin
            buf_in_valid    = 1'b1;
            tx_hold_vld_nxt = 1'b0;
            ev_int[rsp_pkg::EV_TX_FIFO_ERR] = ~buf_in_ready;
         end
      end
      else
      begin
         if (sck_rise)
         begin
            in_sr_nxt   = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
         end
         if (sck_fall)
         begin
            if (bit_cnt_r == rsp_pkg::BIT_FIRST)
            begin
               out_sr_nxt   = nxt_byte_r;
               nxt_byte_nxt = rsp_pkg::BYTE_ZERO;
            end
            else
               out_sr_nxt = {out_sr_r[6:0], 1'b0};
         end
         if (byte_done)
         begin
            case (phase_r)
               rsp_pkg::PH_HEAD:
               begin
                  // Other header bits are assumed zero and not decoded
                  is_cmd_nxt  = rx_byte[rsp_pkg::HDR_AC_BIT];
                  is_read_nxt = rx_byte[rsp_pkg::HDR_RW_BIT];
                  phase_nxt   = rsp_pkg::PH_ADDR;
               end
               rsp_pkg::PH_ADDR:
               begin
                  if (is_cmd_r)
                  begin
                     cmd_valid_nxt = 1'b1;
                     cmd_code_nxt  = rx_byte;
                     phase_nxt     = rsp_pkg::PH_IGNORE;
                  end
                  else
                  begin
                     addr_nxt    = rx_byte;
                     rd_pend_nxt = is_read_r;
                     phase_nxt   = rsp_pkg::PH_DATA;
                  end
               end
               rsp_pkg::PH_DATA:
               begin
                  if (addr_r != rsp_pkg::FIFO_ADDR)
                     addr_nxt = addr_r + rsp_pkg::ADDR_STEP;
                  if (is_read_r)
                     rd_pend_nxt = 1'b1;
                  else if (addr_r == rsp_pkg::FIFO_ADDR)
                  begin
                     // Each byte pushes the one before it; the newest waits
                     if (tx_hold_vld_r)
                     begin
                        buf_in_valid = 1'b1;
                        ev_int[rsp_pkg::EV_TX_FIFO_ERR] = ~buf_in_ready;
                     end
                     tx_hold_nxt     = rx_byte;
                     tx_hold_vld_nxt = 1'b1;
                  end
                  else if (rsp_in_win(addr_r, rsp_pkg::IRQ_MASK_BASE))
                     mask_nxt[8*rsp_win_idx(addr_r, rsp_pkg::IRQ_MASK_BASE) +: 8] = rx_byte;
                  else if (!rsp_in_win(addr_r, rsp_pkg::IRQ_STATUS_BASE))
                  begin
                     reg_wr_nxt    = 1'b1;
                     reg_wdata_nxt = rx_byte;
                  end
               end
               rsp_pkg::PH_IGNORE:
                  phase_nxt = rsp_pkg::PH_IGNORE;
               default:
                  phase_nxt = rsp_pkg::PH_IDLE;
            endcase
         end
      end

      // Read data is fetched one cycle after the byte boundary
      if (fetch_fifo)
      begin
         nxt_byte_nxt = rx_valid ? rx_data : rsp_pkg::BYTE_ZERO;
         ev_int[rsp_pkg::EV_RX_FIFO_ERR] = ~rx_valid;
      end
      else if (fetch_stat)
      begin
         nxt_byte_nxt = status_r[8*rsp_win_idx(addr_r, rsp_pkg::IRQ_STATUS_BASE) +: 8];
         clr_mask[8*rsp_win_idx(addr_r, rsp_pkg::IRQ_STATUS_BASE) +: 8] = 8'hff;
      end
      else if (fetch_mask)
         nxt_byte_nxt = mask_r[8*rsp_win_idx(addr_r, rsp_pkg::IRQ_MASK_BASE) +: 8];
      else if (rd_pend_r)
         nxt_byte_nxt = reg_rdata;

      // An event in the clearing cycle survives: set wins over clear
      status_nxt = ((status_r & ~clr_mask) | event_pulse | ev_int)
                   & rsp_pkg::EV_IMPLEMENTED;

      if (gpio_sel == rsp_pkg::GPIO_SEL_IRQ)
         gpio_nxt = ~(|(status_r & mask_r));
      else
         gpio_nxt = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_r       <= rsp_pkg::PH_IDLE;
         bit_cnt_r     <= rsp_pkg::BIT_FIRST;
         in_sr_r       <= 8'h00;
         out_sr_r      <= 8'h00;
         nxt_byte_r    <= 8'h00;
         is_read_r     <= 1'b0;
         is_cmd_r      <= 1'b0;
         addr_r        <= 8'h00;
         rd_pend_r     <= 1'b0;
         status_r      <= rsp_pkg::STATUS_RST;
         mask_r        <= rsp_pkg::MASK_RST;
         tx_hold_vld_r <= 1'b0;
         tx_hold_r     <= 8'h00;
         reg_wr_r      <= 1'b0;
         reg_wdata_r   <= 8'h00;
         cmd_valid_r   <= 1'b0;
         cmd_code_r    <= 8'h00;
         gpio_r        <= 1'b1;
         cs_sync_r     <= 3'h7;
         sck_sync_r    <= 3'h0;
         mosi_sync_r   <= 2'h0;
      end
      else
      begin
         phase_r       <= phase_nxt;
         bit_cnt_r     <= bit_cnt_nxt;
         in_sr_r       <= in_sr_nxt;
         out_sr_r      <= out_sr_nxt;
         nxt_byte_r    <= nxt_byte_nxt;
         is_read_r     <= is_read_nxt;
         is_cmd_r      <= is_cmd_nxt;
         addr_r        <= addr_nxt;
         rd_pend_r     <= rd_pend_nxt;
         status_r      <= status_nxt;
         mask_r        <= mask_nxt;
         tx_hold_vld_r <= tx_hold_vld_nxt;
         tx_hold_r     <= tx_hold_nxt;
         reg_wr_r      <= reg_wr_nxt;
         reg_wdata_r   <= reg_wdata_nxt;
         cmd_valid_r   <= cmd_valid_nxt;
         cmd_code_r    <= cmd_code_nxt;
         gpio_r        <= gpio_nxt;
         cs_sync_r     <= cs_sync_nxt;
         sck_sync_r    <= sck_sync_nxt;
         mosi_sync_r   <= mosi_sync_nxt;
      end
   end

   // ------------------------------------------------------------
   // Transmit path buffer
   // ------------------------------------------------------------
   // A full buffer cannot stall the host clock, so a refused byte is
   // reported as a transmit FIFO error instead of being silently lost.
   rsp_buf2 u_txbuf
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (tx_hold_r),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_data)
   );

endmodule

// file: verification/rsp_port_asserts.sv
// Concurrent checks on the serial host port pins and side ports.
// Assumes one clk domain with rst_n, bound to every rsp_port.
`timescale 1ns/1ps
module rsp_port_asserts
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       chip_select_low,
   input wire logic       sclk,
   input wire logic       miso_o,
   input wire logic       miso_oe_n,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       cmd_valid,
   input wire logic       rx_valid,
   input wire logic       rx_ready,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic [4:0] gpio_sel,
   input wire logic       gpio_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // Serial pin
   // ------------------------------------------------------------
   a_miso_released: assert property (chip_select_low[*5] |-> miso_oe_n)
      else $error("miso driven while deselected");
   a_miso_driven: assert property ((!chip_select_low)[*5] |-> !miso_oe_n)
      else $error("miso not driven while selected");
   a_miso_steady_high: assert property (sclk[*4] |-> $stable(miso_o))
      else $error("miso changed while bit clock high");
   // ------------------------------------------------------------
   // Side ports and interrupt pin
   // ------------------------------------------------------------
   a_wr_single_shot: assert property (reg_wr |=> (!reg_wr)[*8])
      else $error("more than one write per byte");
   a_rd_single_shot: assert property (reg_rd |=> (!reg_rd)[*8])
      else $error("more than one fetch per byte");
   a_cmd_once_selected: assert property (cmd_valid |-> !chip_select_low ##1 (!cmd_valid)[*8])
      else $error("command pulse repeated or outside select");
   a_rx_pop_guard: assert property (rx_ready |-> rx_valid && !chip_select_low ##1 !rx_ready)
      else $error("receive pop while empty, deselected or repeated");
   a_tx_hold_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("transmit byte lost under stall");
   a_irq_other_sel: assert property ((gpio_sel != 5'h00)[*4] |-> gpio_out)
      else $error("pin low under another selection");
   a_irq_fall_sel: assert property ($fell(gpio_out) |-> $past(gpio_sel) == 5'h00)
      else $error("pin fell without request selection");
endmodule

bind rsp_port rsp_port_asserts rsp_port_asserts_i (.clk(clk), .rst_n(rst_n),
   .chip_select_low(chip_select_low), .sclk(sclk), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .cmd_valid(cmd_valid), .rx_valid(rx_valid),
   .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
   .gpio_sel(gpio_sel), .gpio_out(gpio_out));

// file: verification/rsp_host_model.sv
// Serial master model: select, bit clock and data toward the port.
// Runs on its own delays, offset from clk so no edge races the port.
`timescale 1ns/1ps
module rsp_host_model
(
   output logic       chip_select_low,
   output logic       sclk,
   output logic       mosi,
   input  wire logic  miso_o,
   input  wire logic  miso_oe_n,
   output logic [7:0] got_byte,
   output int         got_cnt
);
   logic last = 1'b0;
   initial
   begin
      chip_select_low = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      got_byte = 8'h00;
      got_cnt = 0;
   end
   task automatic start();
      #7;
      chip_select_low = 1'b0;
      #2000;
   endtask
   task automatic stop();
      #200;
      chip_select_low = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
   // Half period 80 ns: 6.25 MHz; a released line reads as the inverse
   task automatic xb(input logic [7:0] v, input bit keep);
      logic [7:0] r;
      for (int i = 7; i >= 0; i--)
      begin
         mosi = v[i];
         #80;
         sclk = 1'b1;
         r[i] = miso_oe_n ? ~last : miso_o;
         last = r[i];
         #80;
         sclk = 1'b0;
      end
      if (keep)
      begin
         got_byte = r;
         got_cnt++;
      end
   endtask
endmodule

// file: verification/tb.sv
// Testbench for the serial host port: registers, commands, FIFOs, events.
// Expectations queue per stream; watchers compare as results appear.
`timescale 1ns/1ps
module tb;
   logic        clk, chip_select_low, sclk, mosi, miso_o, miso_oe_n;
   logic        reg_wr, reg_rd, cmd_valid, rx_ready, tx_valid, gpio_out;
   logic        rst_n = 1'b0;
   logic        rx_valid = 1'b0;
   logic        tx_ready = 1'b0;
   logic        tx_rnd = 1'b0;
   logic [15:0] msb = 16'h0000;
   logic [31:0] event_pulse = 32'h0000_0000;
   logic [4:0]  gpio_sel = 5'h00;
   logic [7:0]  rx_data = 8'h00;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, cmd_code, tx_data, got_byte;
   logic [7:0]  d [4], e [4], z [4];
   logic [15:0] qw[$], qc[$], qt[$], qm[$];
   logic [7:0]  rxq[$];
   int          got_cnt, seed = 32, mismatches = 0, check_count = 0, cycles = 0;

   rsp_port rsp_port_i (.clk(clk), .rst_n(rst_n), .chip_select_low(chip_select_low), .sclk(sclk),
      .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .machine_status_bytes(msb),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .event_pulse(event_pulse), .gpio_sel(gpio_sel), .gpio_out(gpio_out));
   rsp_host_model rsp_host_model_i (.chip_select_low(chip_select_low), .sclk(sclk), .mosi(mosi),
      .miso_o(miso_o), .miso_oe_n(miso_oe_n), .got_byte(got_byte), .got_cnt(got_cnt));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   assign reg_rdata = reg_addr ^ 8'ha5;
   // ------------------------------------------------------------
   // Far-side models and result watchers
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rx_ready === 1'b1 && rxq.size() != 0)
         void'(rxq.pop_front());
      rx_valid <= rxq.size() != 0;
      rx_data <= rxq.size() != 0 ? rxq[0] : 8'h00;
      tx_ready <= tx_rnd && ($random(seed) & 1);
   end
   function automatic logic [15:0] take(ref logic [15:0] q[$]);
      take = q.size() != 0 ? q.pop_front() : 16'hxxxx;
   endfunction
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
      check_count++;
      if (g !== ex)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, ex, g);
      end
   endtask
   always @(posedge clk)
   begin
      if (reg_wr === 1'b1)
         chk("reg_wr", take(qw), {reg_addr, reg_wdata});
      if (cmd_valid === 1'b1)
         chk("cmd_code", take(qc), {8'h00, cmd_code});
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         chk("tx_data", take(qt), {8'h00, tx_data});
   end
   always @(got_cnt)
      chk("miso", take(qm), {8'h00, got_byte});
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         $display("[ERR] timeout expected done seen hang");
         summarize();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic fill();
      foreach (d[i])
         d[i] = 8'($random(seed));
   endtask
   task automatic pulse(input logic [31:0] v);
      @(posedge clk);
      event_pulse <= v;
      @(posedge clk);
      event_pulse <= 32'h0000_0000;
      repeat (6) @(posedge clk);
   endtask
   // Header and address bytes return the two status bytes
   task automatic txn(input logic [7:0] h, input logic [7:0] a, input int n, input int nc,
                      input logic [7:0] dv [4], input logic [7:0] ev [4]);
      @(posedge clk);
      msb <= 16'($random(seed));
      @(posedge clk);
      qm.push_back({8'h00, msb[15:8]});
      qm.push_back({8'h00, msb[7:0]});
      rsp_host_model_i.start();
      rsp_host_model_i.xb(h, 1'b1);
      rsp_host_model_i.xb(a, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         if (i < nc)
            qm.push_back({8'h00, ev[i]});
         rsp_host_model_i.xb(dv[i], i < nc);
      end
      rsp_host_model_i.stop();
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      z = '{default: 8'h00};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      fill();
      for (int i = 0; i < 3; i++)
         qw.push_back({8'h10 + 8'(i), d[i]});
      txn(8'h00, 8'h10, 3, 3, d, z);
      for (int i = 0; i < 3; i++)
         e[i] = (8'h7e + 8'(i)) ^ 8'ha5;
      txn(8'h01, 8'h7e, 3, 3, d, e);
      for (int k = 0; k < 2; k++)
      begin
         qc.push_back({8'h00, d[k]});
         txn(8'h80 + 8'(k), d[k], 1, 0, d, z);
      end
      e = '{default: 8'hff};
      txn(8'h00, 8'h90, 4, 4, e, z);
      pulse(32'hffff_ffff);
      chk("irq_pin", 16'h0000, {15'h0000, gpio_out});
      gpio_sel <= 5'h01 | 5'($random(seed));
      repeat (6) @(posedge clk);
      chk("irq_pin", 16'h0001, {15'h0000, gpio_out});
      gpio_sel <= 5'h00;
      repeat (6) @(posedge clk);
      chk("irq_pin", 16'h0000, {15'h0000, gpio_out});
      e = '{8'hff, 8'hff, 8'h3f, 8'h60};
      txn(8'h01, 8'hfa, 4, 4, d, e);
      chk("irq_pin", 16'h0001, {15'h0000, gpio_out});
      txn(8'h01, 8'hfa, 4, 4, d, z);
      txn(8'h00, 8'h90, 4, 4, z, z);
      pulse(32'h0000_0008);
      chk("irq_pin", 16'h0001, {15'h0000, gpio_out});
      e = '{8'h08, 8'h00, 8'h00, 8'h00};
      txn(8'h01, 8'hfa, 1, 1, d, e);
      fill();
      rxq.push_back(d[0]);
      rxq.push_back(d[1]);
      e = '{d[0], d[1], 8'h00, 8'h00};
      txn(8'h01, 8'hff, 3, 3, d, e);
      // Stalled sink: two bytes fit, the rest are refused and flagged
      fill();
      qt.push_back({8'h00, d[0]});
      qt.push_back({8'h00, d[1]});
      txn(8'h00, 8'hff, 4, 4, d, z);
      txn(8'h01, 8'h00, 0, 0, d, z);
      repeat (20) @(posedge clk);
      tx_rnd <= 1'b1;
      repeat (50) @(posedge clk);
      fill();
      qt.push_back({8'h00, d[0]});
      qt.push_back({8'h00, d[1]});
      txn(8'h00, 8'hff, 2, 2, d, z);
      e = '{8'h60, 8'h00, 8'h00, 8'h00};
      txn(8'h01, 8'hfa, 1, 1, d, e);
      repeat (100) @(posedge clk);
      chk("pending", 16'h0000, 16'(qw.size() + qc.size() + qt.size() + qm.size()));
      summarize();
   end
endmodule
